// ===== rtl/mfx_defines.svh
// Constants for the memory field extender
// Notes on behaviour
// [RL1] Drive a 3-bit extended address selecting one of eight 4096-word fields.
// [RL2] Active code bank never increments when the program counter wraps.
// [RL3] Fetches, direct operands and indirect pointers use the active code bank.
// [RL4] Indirect and/add/isz/deposit operands use the operand bank; jumps use code bank.
// [RL5] Operand bank only in execute directly after indirect phase of those four.
// [RL6] Pending bank copies to active bank on next jump/call or commit op.
// [RL7] No jump/call copy when fetched from control panel memory.
// [RL8] Interrupt grant saves pending and operand banks, then clears all three banks.
// [RL9] Changing the pending bank sets the interrupt block latch until jump/call.
// [RL10] Get flags: latch on bit 3, saved banks on bits 6-11, both control lines low.
// [RL11] Return flags: accumulator bits 6-8 to pending, 9-11 to operand in state six.
// [RL12] Change operand bank loads field number from instruction; accumulator untouched.
// [RL13] Change code bank loads pending bank and sets the block latch.
// [RL14] Combined code loads both banks and sets the block latch.
// [RL15] Read operand bank onto bits 6-8, others zero, control line 1 low.
// [RL16] Read code bank the same way as the operand bank read.
// [RL17] Read saved banks onto bits 6-11, control line 1 low.
// [RL18] Restore loads pending and operand banks from saved banks, sets block latch.
// [RL19] Commit op copies pending bank to active bank and clears block latch.
// [RL20] System reset clears operand and code banks.
// [RL21] During an I/O execute the control lines name the operation.
// [RL22] Respond only with peripheral select and a matching operation code.
`ifndef MFX_DEFINES_SVH
`define MFX_DEFINES_SVH

`define MFX_FIELD_WORDS    4096
`define MFX_OP_GET_FLAGS   12'hc04
`define MFX_OP_RET_FLAGS   12'hc05
`define MFX_OP_READ_OPB    12'hc8c
`define MFX_OP_READ_CODE   12'hc94
`define MFX_OP_READ_SAVED  12'hc9c
`define MFX_OP_RESTORE     12'hca4
`define MFX_OP_COMMIT      12'hcac
`define MFX_CHG_PREFIX     6'h32
`define MFX_SUB_CHG_OPB    3'h1
`define MFX_SUB_CHG_CODE   3'h2
`define MFX_SUB_CHG_BOTH   3'h3
`define MFX_BANK_RESET     3'h0
`define MFX_SAVED_RESET    6'h00
`define MFX_BIT_LATCH      8
`define MFX_OPC_AND        3'h0
`define MFX_OPC_DCA        3'h3
`define MFX_OPC_JMS        3'h4
`define MFX_OPC_JMP        3'h5

`endif

// ===== rtl/mfx_pkg.sv
// Types shared by the memory field extender files
package mfx_pkg;
    typedef struct packed {
        logic       ctl0_low;
        logic       ctl1_low;
        logic [11:0] data;
        logic       drive;
    } mfx_io_reply_type;

    typedef enum logic [3:0] {
        MFX_NONE, MFX_GTF, MFX_RTF, MFX_CHG_OPB, MFX_CHG_CODE, MFX_CHG_BOTH,
        MFX_RD_OPB, MFX_RD_CODE, MFX_RD_SAVED, MFX_RESTORE, MFX_COMMIT
    } mfx_op_type;
endpackage

// ===== rtl/mfx_op_decode.sv
// Decoder of transfer instruction words for the memory field extender
`timescale 1ns/1ps
`include "mfx_defines.svh"
module mfx_op_decode
(
    input  wire logic [11:0]        instr_in,
    input  wire logic               sel_in,
    output mfx_pkg::mfx_op_type     op_out
);
    always_comb
    begin
        op_out = mfx_pkg::MFX_NONE;
        if (sel_in)                                                   // [RL22]
        begin
            if (instr_in == `MFX_OP_GET_FLAGS)
                op_out = mfx_pkg::MFX_GTF;
            else if (instr_in == `MFX_OP_RET_FLAGS)
                op_out = mfx_pkg::MFX_RTF;
            else if (instr_in == `MFX_OP_READ_OPB)
                op_out = mfx_pkg::MFX_RD_OPB;
            else if (instr_in == `MFX_OP_READ_CODE)
                op_out = mfx_pkg::MFX_RD_CODE;
            else if (instr_in == `MFX_OP_READ_SAVED)
                op_out = mfx_pkg::MFX_RD_SAVED;
            else if (instr_in == `MFX_OP_RESTORE)
                op_out = mfx_pkg::MFX_RESTORE;
            else if (instr_in == `MFX_OP_COMMIT)
                op_out = mfx_pkg::MFX_COMMIT;
            else if (instr_in[11:6] == `MFX_CHG_PREFIX)
            begin
                if (instr_in[2:0] == `MFX_SUB_CHG_OPB)
                    op_out = mfx_pkg::MFX_CHG_OPB;
                else if (instr_in[2:0] == `MFX_SUB_CHG_CODE)
                    op_out = mfx_pkg::MFX_CHG_CODE;
                else if (instr_in[2:0] == `MFX_SUB_CHG_BOTH)
                    op_out = mfx_pkg::MFX_CHG_BOTH;
            end
        end
    end
endmodule

// ===== rtl/mfx_core.sv
// Memory field extender: bank registers, address extension, interrupt gating
`timescale 1ns/1ps
`include "mfx_defines.svh"
module mfx_core
(
    input  wire logic        sys_clk_in,
    input  wire logic        srst_in,
    input  wire logic        reset_n_in,
    input  wire logic [11:0] instr_in,
    input  wire logic        peripheral_select_n_in,
    input  wire logic        io_state_six_in,
    input  wire logic [11:0] multiplexed_bus_lines_in,
    input  wire logic        exec_phase_in,
    input  wire logic        indirect_prev_in,
    input  wire logic        panel_fetch_in,
    input  wire logic        operand_bank_select_in,
    input  wire logic        interrupt_grant_cycle_in,
    input  wire logic        dev_irq_in,
    output logic [2:0]       ext_addr_out,
    output logic [11:0]      multiplexed_bus_lines_out,
    output logic             multiplexed_bus_lines_oe_n_out,
    output logic             io_control_line_0_oe_n_out,
    output logic             io_control_line_1_oe_n_out,
    output logic             interrupt_request_line_out,
    output logic             interrupt_block_latch_out
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync_next;
    logic       rst_pin_n;
    logic       sel_n;
    logic       state_six;
    logic       grant;
    logic       irq_src;
    always_comb
    begin
        sync_next = {reset_n_in, peripheral_select_n_in, io_state_six_in,
                     interrupt_grant_cycle_in, dev_irq_in};
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            sync1_reg <= 5'h1_8;
            sync2_reg <= 5'h1_8;
        end
        else
        begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end
    assign {rst_pin_n, sel_n, state_six, grant, irq_src} = sync2_reg;

    // ------------------------------------------------------------
    // Instruction decode and event edges
    // ------------------------------------------------------------
    mfx_pkg::mfx_op_type op;
    logic six_prev_reg;
    logic grant_prev_reg;
    logic six_rise;
    logic grant_rise;
    mfx_op_decode u_dec
    (
        .instr_in (instr_in),
        .sel_in   (~sel_n),
        .op_out   (op)
    );
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            six_prev_reg   <= 1'b0;
            grant_prev_reg <= 1'b0;
        end
        else
        begin
            six_prev_reg   <= state_six;
            grant_prev_reg <= grant;
        end
    end
    assign six_rise   = state_six & ~six_prev_reg;
    assign grant_rise = grant & ~grant_prev_reg;

    // Jump or call in execute phase from either memory; panel fetches are excluded at the copy
    logic is_jump;
    logic is_operand_op;
    assign is_jump       = exec_phase_in && (instr_in[11:9] == `MFX_OPC_JMP || instr_in[11:9] == `MFX_OPC_JMS);
    assign is_operand_op = instr_in[11:9] <= `MFX_OPC_DCA;

    // ------------------------------------------------------------
    // Bank registers
    // ------------------------------------------------------------
    logic [2:0] code_bank_reg;
    logic [2:0] code_bank_next;
    logic [2:0] operand_bank_reg;
    logic [2:0] operand_bank_next;
    logic [2:0] pending_bank_reg;
    logic [2:0] pending_bank_next;
    logic [5:0] saved_banks_reg;
    logic [5:0] saved_banks_next;
    logic       block_reg;
    logic       block_next;
    logic       jump_done_reg;
    logic       jump_done_next;
    always_comb
    begin
        code_bank_next    = code_bank_reg;
        operand_bank_next = operand_bank_reg;
        pending_bank_next = pending_bank_reg;
        saved_banks_next  = saved_banks_reg;
        block_next        = block_reg;
        jump_done_next    = is_jump;
        if (!rst_pin_n)
        begin
            code_bank_next    = `MFX_BANK_RESET;                    // [RL20]
            operand_bank_next = `MFX_BANK_RESET;                    // [RL20]
            pending_bank_next = `MFX_BANK_RESET;
            block_next        = 1'b0;
        end
        else if (grant_rise)
        begin
            // Pending bank on top, so a get-flags reply feeds return flags unchanged
            saved_banks_next  = {pending_bank_reg, operand_bank_reg}; // [RL8]
            code_bank_next    = `MFX_BANK_RESET;                    // [RL8]
            pending_bank_next = `MFX_BANK_RESET;
            operand_bank_next = `MFX_BANK_RESET;
        end
        else if (six_rise)
        begin
            unique case (op)
                mfx_pkg::MFX_RTF:
                begin
                    pending_bank_next = multiplexed_bus_lines_in[5:3];   // [RL11]
                    operand_bank_next = multiplexed_bus_lines_in[2:0];   // [RL11]
                    block_next        = 1'b1;                            // [RL9]
                end
                mfx_pkg::MFX_CHG_OPB:
                    operand_bank_next = instr_in[5:3];                   // [RL12]
                mfx_pkg::MFX_CHG_CODE:
                begin
                    pending_bank_next = instr_in[5:3];                   // [RL13]
                    block_next        = 1'b1;                            // [RL9]
                end
                mfx_pkg::MFX_CHG_BOTH:
                begin
                    operand_bank_next = instr_in[5:3];                   // [RL14]
                    pending_bank_next = instr_in[5:3];                   // [RL14]
                    block_next        = 1'b1;
                end
                mfx_pkg::MFX_RESTORE:
                begin
                    pending_bank_next = saved_banks_reg[5:3];            // [RL18]
                    operand_bank_next = saved_banks_reg[2:0];            // [RL18]
                    block_next        = 1'b1;
                end
                mfx_pkg::MFX_COMMIT:
                begin
                    code_bank_next = pending_bank_reg;                   // [RL19]
                    block_next     = 1'b0;                               // [RL19]
                end
                default:
                begin
                end
            endcase
        end
        else if (is_jump && !jump_done_reg && !panel_fetch_in)       // [RL7]
        begin
            code_bank_next = pending_bank_reg;                           // [RL6]
            block_next     = 1'b0;                                       // [RL9]
        end
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            code_bank_reg    <= `MFX_BANK_RESET;
            operand_bank_reg <= `MFX_BANK_RESET;
            pending_bank_reg <= `MFX_BANK_RESET;
            saved_banks_reg  <= `MFX_SAVED_RESET;
            block_reg        <= 1'b0;
            jump_done_reg    <= 1'b0;
        end
        else
        begin
            code_bank_reg    <= code_bank_next;
            operand_bank_reg <= operand_bank_next;
            pending_bank_reg <= pending_bank_next;
            saved_banks_reg  <= saved_banks_next;
            block_reg        <= block_next;
            jump_done_reg    <= jump_done_next;
        end
    end

    // ------------------------------------------------------------
    // Extended address
    // ------------------------------------------------------------
    // Code bank has no carry input, so program counter wrap cannot touch it
    logic use_operand;
    logic [2:0] ext_addr_reg;
    assign use_operand = operand_bank_select_in && exec_phase_in && indirect_prev_in && is_operand_op; // [RL5]
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            ext_addr_reg <= `MFX_BANK_RESET;
        else
            ext_addr_reg <= use_operand ? operand_bank_reg : code_bank_reg; // [RL1] [RL2] [RL3] [RL4]
    end
    assign ext_addr_out = ext_addr_reg;

    // ------------------------------------------------------------
    // Transfer replies
    // ------------------------------------------------------------
    mfx_pkg::mfx_io_reply_type reply;
    mfx_pkg::mfx_io_reply_type reply_reg;
    always_comb
    begin
        reply = '{ctl0_low: 1'b0, ctl1_low: 1'b0, data: 12'h000, drive: 1'b0};
        unique case (op)
            mfx_pkg::MFX_GTF:
            begin
                reply.data[`MFX_BIT_LATCH] = block_reg;                  // [RL10]
                reply.data[5:0] = saved_banks_reg;                       // [RL10]
                reply.ctl0_low = 1'b1;                                   // [RL10] [RL21]
                reply.ctl1_low = 1'b1;
                reply.drive    = 1'b1;
            end
            mfx_pkg::MFX_RD_OPB:
            begin
                reply.data[5:3] = operand_bank_reg;                      // [RL15]
                reply.ctl1_low = 1'b1;                                   // [RL21]
                reply.drive    = 1'b1;
            end
            mfx_pkg::MFX_RD_CODE:
            begin
                reply.data[5:3] = code_bank_reg;                         // [RL16]
                reply.ctl1_low = 1'b1;
                reply.drive    = 1'b1;
            end
            mfx_pkg::MFX_RD_SAVED:
            begin
                reply.data[5:0] = saved_banks_reg;                       // [RL17]
                reply.ctl1_low = 1'b1;
                reply.drive    = 1'b1;
            end
            default:
            begin
            end
        endcase
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            reply_reg <= '{ctl0_low: 1'b0, ctl1_low: 1'b0, data: 12'h000, drive: 1'b0};
        else
            reply_reg <= reply;
    end
    // Bus bit 0 is the most significant; data is held LSB-numbered internally
    assign multiplexed_bus_lines_out      = reply_reg.data;
    assign multiplexed_bus_lines_oe_n_out = ~reply_reg.drive;
    assign io_control_line_0_oe_n_out     = ~reply_reg.ctl0_low;
    assign io_control_line_1_oe_n_out     = ~reply_reg.ctl1_low;
    assign interrupt_request_line_out     = irq_src & ~block_reg;        // [RL9]
    assign interrupt_block_latch_out      = block_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_commit;
        six_rise && op == mfx_pkg::MFX_COMMIT && rst_pin_n && !grant_rise;
    endsequence
    chk_commit_copy: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL19]
        s_commit |=> code_bank_reg == $past(pending_bank_reg) && !block_reg)
        else $error("commit did not copy pending bank");
    chk_chg_block: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL13]
        six_rise && op == mfx_pkg::MFX_CHG_CODE && rst_pin_n && !grant_rise |=> block_reg)
        else $error("change code bank did not block");
    chk_irq_gate: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL9]
        block_reg |-> !interrupt_request_line_out)
        else $error("interrupt passed while blocked");
    chk_grant_save: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL8]
        grant_rise && rst_pin_n |=> saved_banks_reg == {$past(pending_bank_reg), $past(operand_bank_reg)}
        && code_bank_reg == 3'h0)
        else $error("grant save wrong");
    chk_reset_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL20]
        !rst_pin_n |=> code_bank_reg == 3'h0 && operand_bank_reg == 3'h0)
        else $error("reset did not clear banks");
    chk_panel_jump: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL7]
        panel_fetch_in && rst_pin_n && !grant_rise && !six_rise |=> $stable(code_bank_reg))
        else $error("panel jump changed code bank");
    chk_read_lines: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL15]
        op == mfx_pkg::MFX_RD_OPB |=> !io_control_line_1_oe_n_out && multiplexed_bus_lines_out[11:6] == 6'h00)
        else $error("read operand bank reply wrong");
    chk_gtf_lines: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL10]
        op == mfx_pkg::MFX_GTF |=> !io_control_line_0_oe_n_out && !io_control_line_1_oe_n_out)
        else $error("get flags control lines wrong");
    chk_addr_sel: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL5]
        !use_operand |=> ext_addr_out == $past(code_bank_reg))
        else $error("operand bank used outside indirect execute");
    chk_rtf_load: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL11]
        six_rise && op == mfx_pkg::MFX_RTF && rst_pin_n && !grant_rise |=> block_reg
        && {pending_bank_reg, operand_bank_reg} == $past(multiplexed_bus_lines_in[5:0]))
        else $error("return flags load wrong");
    chk_restore_load: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL18]
        six_rise && op == mfx_pkg::MFX_RESTORE && rst_pin_n && !grant_rise |=> block_reg
        && {pending_bank_reg, operand_bank_reg} == $past(saved_banks_reg))
        else $error("restore load wrong");
    chk_jump_copy: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RL6]
        is_jump && !jump_done_reg && !panel_fetch_in && rst_pin_n && !grant_rise && !six_rise
        |=> code_bank_reg == $past(pending_bank_reg) && !block_reg)
        else $error("jump did not copy pending bank");
endmodule

// ===== dv/mfx_cpu_model.sv
// Processor-side bus model that drives the memory field extender pins
`timescale 1ns/1ps
module mfx_cpu_model
(
    input  wire logic        clk_in,
    output logic             reset_n_out,
    output logic [11:0]      instr_out,
    output logic             sel_n_out,
    output logic             six_out,
    output logic [11:0]      acc_out,
    output logic             exec_out,
    output logic             ind_out,
    output logic             panel_out,
    output logic             dsel_out,
    output logic             grant_out,
    output logic             irq_out
);
    initial
    begin
        {reset_n_out, sel_n_out, instr_out, acc_out} = {2'b11, 24'h00_0fff};
        {six_out, exec_out, ind_out, panel_out, dsel_out, grant_out, irq_out} = 7'h00;
    end

    // ------------------------------------------------------------
    // Transfer cycles
    // ------------------------------------------------------------
    // Request holds through state six until iot_end releases it
    task automatic io_transfer_instruction(input logic [11:0] code, input logic [11:0] acc, input logic sel);
        @(negedge clk_in);
        instr_out = code;
        acc_out   = acc;
        sel_n_out = ~sel;
        repeat (2) @(negedge clk_in);
        six_out = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask

    // Released lines show the inverse, so a stale capture cannot pass
    task automatic iot_end;
        six_out   = 1'b0;
        sel_n_out = 1'b1;
        acc_out   = ~acc_out;
        repeat (6) @(negedge clk_in);
    endtask

    // ------------------------------------------------------------
    // Memory reference cycles, grant and reset pin
    // ------------------------------------------------------------
    task automatic mem_start(input logic [2:0] opc, input logic ind, input logic panel);
        instr_out = {opc, 9'h0a5};
        ind_out   = ind;
        panel_out = panel;
        dsel_out  = ind && (opc < 3'h4);
        exec_out  = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask

    task automatic mem_end;
        {exec_out, ind_out, panel_out, dsel_out} = 4'h0;
        repeat (4) @(negedge clk_in);
    endtask

    task automatic grant;
        grant_out = 1'b1;
        repeat (6) @(negedge clk_in);
        grant_out = 1'b0;
        repeat (6) @(negedge clk_in);
    endtask

    task automatic raise_irq;
        irq_out = 1'b1;
    endtask

    task automatic pin_reset;
        reset_n_out = 1'b0;
        repeat (6) @(negedge clk_in);
        reset_n_out = 1'b1;
        repeat (6) @(negedge clk_in);
    endtask
endmodule

// ===== dv/test_memory_field_extender.sv
// Self-checking bench for the memory field extender core
`timescale 1ns/1ps
module test_memory_field_extender;
    logic        sys_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        reset_n_in, peripheral_select_n_in, io_state_six_in, exec_phase_in, indirect_prev_in;
    logic        panel_fetch_in, operand_bank_select_in, interrupt_grant_cycle_in, dev_irq_in;
    logic [11:0] instr_in, multiplexed_bus_lines_in, multiplexed_bus_lines_out, acc;
    logic [2:0]  ext_addr_out;
    logic        multiplexed_bus_lines_oe_n_out, io_control_line_0_oe_n_out, io_control_line_1_oe_n_out;
    logic        interrupt_request_line_out, interrupt_block_latch_out;
    int          error_cnt = 0, checks_done = 0, cycles = 0, code, pend, opb, saved, latch, i, k;
    integer      seed = 32'h70d2_fb06;

    mfx_cpu_model cpu_u
    (
        .clk_in(sys_clk_in), .reset_n_out(reset_n_in), .instr_out(instr_in), .sel_n_out(peripheral_select_n_in),
        .six_out(io_state_six_in), .acc_out(multiplexed_bus_lines_in), .exec_out(exec_phase_in),
        .ind_out(indirect_prev_in), .panel_out(panel_fetch_in), .dsel_out(operand_bank_select_in),
        .grant_out(interrupt_grant_cycle_in), .irq_out(dev_irq_in)
    );

    mfx_core dut_u
    (
        .sys_clk_in, .srst_in, .reset_n_in, .instr_in, .peripheral_select_n_in, .io_state_six_in,
        .multiplexed_bus_lines_in, .exec_phase_in, .indirect_prev_in, .panel_fetch_in, .operand_bank_select_in,
        .interrupt_grant_cycle_in, .dev_irq_in, .ext_addr_out, .multiplexed_bus_lines_out,
        .multiplexed_bus_lines_oe_n_out, .io_control_line_0_oe_n_out, .io_control_line_1_oe_n_out,
        .interrupt_request_line_out, .interrupt_block_latch_out
    );

    always #4 sys_clk_in = ~sys_clk_in;

    // Whole run needs about 1540 cycles; this bound only catches hangs
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        if (seen !== exp)
            error_cnt++;
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic rd(input logic [11:0] op, input logic [11:0] exp, input logic [1:0] ctl);
        cpu_u.io_transfer_instruction(op, 12'($random(seed)), 1'b1);
        chk(multiplexed_bus_lines_out, exp);
        chk({multiplexed_bus_lines_oe_n_out, io_control_line_0_oe_n_out, io_control_line_1_oe_n_out}, {1'b0, ctl});
        cpu_u.iot_end();
    endtask

    task automatic op(input logic [11:0] c);
        acc = 12'($random(seed));
        cpu_u.io_transfer_instruction(c, acc, 1'b1);
        cpu_u.iot_end();
    endtask

    // Reads back the operand, code and saved banks and the latch through the bus and compares with the model
    task automatic check_all;
        rd(12'hc8c, {6'h00, 3'(opb), 3'h0}, 2'b10);
        rd(12'hc94, {6'h00, 3'(code), 3'h0}, 2'b10);
        rd(12'hc9c, {6'h00, 6'(saved)}, 2'b10);
        rd(12'hc04, {3'h0, 1'(latch), 2'h0, 6'(saved)}, 2'b00);
        chk(interrupt_block_latch_out, 16'(latch));
        chk(interrupt_request_line_out, 16'(latch == 0));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {code, pend, opb, saved, latch} = '0;
        repeat (12) @(negedge sys_clk_in);
        srst_in = 1'b0;
        cpu_u.raise_irq();
        check_all();
        for (i = 0; i < 8; i++)
        begin
            k = i % 3 + 1;
            op(12'hc80 | 12'(i * 8 + k));
            if (k != 2)
                opb = i;
            if (k != 1)
                pend = i;
            if (k != 1)
                latch = 1;
            check_all();
        end
        op(12'hcac);
        code = pend;
        latch = 0;
        check_all();
        op(12'hc05);
        pend = acc[5:3];
        opb = acc[2:0];
        latch = 1;
        check_all();
        cpu_u.mem_start(3'h5, 1'b0, 1'b1);
        cpu_u.mem_end();
        check_all();
        cpu_u.mem_start(3'h4, 1'b0, 1'b0);
        cpu_u.mem_end();
        code = pend;
        latch = 0;
        check_all();
        opb = (code + 1) % 8;
        op(12'hc81 | 12'(opb * 8));
        for (i = 0; i < 16; i++)
        begin
            cpu_u.mem_start(3'(i / 2), 1'(i), 1'b0);
            if (i / 2 != 4 && i / 2 != 5)
                chk(ext_addr_out, 16'((i % 2 == 1 && i / 2 < 4) ? opb : code));
            cpu_u.mem_end();
        end
        op(12'hcaa);
        op(12'hcac);
        code = 5;
        pend = 5;
        cpu_u.grant();
        saved = pend * 8 + opb;
        {code, pend, opb} = '0;
        check_all();
        op(12'hca4);
        pend = saved / 8;
        opb = saved % 8;
        latch = 1;
        check_all();
        cpu_u.io_transfer_instruction(12'hc8d, 12'h0ff, 1'b1);
        chk(multiplexed_bus_lines_oe_n_out, 16'h0001);
        cpu_u.iot_end();
        cpu_u.io_transfer_instruction(12'hc8c, 12'h0ff, 1'b0);
        chk(multiplexed_bus_lines_oe_n_out, 16'h0001);
        cpu_u.iot_end();
        cpu_u.pin_reset();
        {code, pend, opb, latch} = '0;
        check_all();
        end_sim();
    end
endmodule
